// [core/dlt_core.sv]
// Purpose: ADC unload over the serial port and timed DAC load from the holding register
// Assumes: Link bit clock is far slower than sys_clk_i and is sampled, not used as a clock
// Notes: Frame and data change on link clock rising edges, input bits are taken on falling ones
// Contract
// [R01] With zero advance, DAC loads just before ADC word loads and frame sync rises; the code does all three in the same sys_clk_i cycle.
// [R02] The DAC load instant can be moved earlier than the frame sync.
// [R03] Frame sync rises to announce a fresh ADC word for unloading.
// [R04] After frame sync, 16 ADC bits leave MSB first, one per bit clock.
// [R05] A completed incoming DAC word goes into the holding register; the code stores it only when the frame count equals device_count_i.
// [R06] Programmed advance moves the DAC load earlier by that many bit clocks.
// [R07] In mixed mode only MSB-zero words are DAC data and advance frame counting.
// [R08] The far end must finish each DAC word before the chosen load instant.
`timescale 1ns/100ps
`include "dlt_params.svh"

module dlt_core #(
	parameter int SAMPLE_SCLKS = `DLT_SAMPLE_SCLKS,
	parameter int ADV_BITS = `DLT_ADV_BITS
) (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic sclk_i,
	input wire logic input_frame_sync_i,
	input wire logic serial_data_in_i,
	input wire logic [15:0] adc_word_i,
	input wire logic [ADV_BITS-1:0] dac_advance_i,
	input wire logic mixed_mode_i,
	input wire logic [2:0] device_count_i,
	output logic output_frame_sync_o,
	output logic serial_data_out_o,
	output dlt_pkg::dlt_word_t dac_o,
	output dlt_pkg::dlt_word_t ctrl_o,
	output logic [15:0] holding_o
);
	import dlt_pkg::*;

	localparam int CW = $clog2(SAMPLE_SCLKS);

	if (SAMPLE_SCLKS < `DLT_WORD_BITS + 2 || (2 ** ADV_BITS) > SAMPLE_SCLKS) begin : g_chk
		$error("dlt_core: SAMPLE_SCLKS too small for word or advance range");
	end

	function automatic logic is_dac_word(input logic [15:0] w, input logic mixed);
		is_dac_word = !mixed || !w[15];
	endfunction

	logic [2:0] lvl;
	logic [2:0] rise;
	logic [2:0] fall;

	dlt_sync_edge #(
		.WIDTH(3)
	) u_sync (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.async_i({serial_data_in_i, input_frame_sync_i, sclk_i}),
		.level_o(lvl),
		.rise_o(rise),
		.fall_o(fall)
	);

	logic sclk_rise;
	logic sclk_fall;
	logic ifs_lvl;
	logic sdi_lvl;
	assign sclk_rise = rise[0];
	assign sclk_fall = fall[0];
	assign ifs_lvl = lvl[1];
	assign sdi_lvl = lvl[2];

	// Sample timer and transmit side
	logic [CW-1:0] cnt_q, cnt_d;
	logic [CW-1:0] load_pt;
	logic frame_start;
	logic load_now;
	dlt_tx_state_t tx_q, tx_d;
	logic [4:0] txbit_q, txbit_d;
	logic [15:0] txsr_q, txsr_d;
	logic ofs_q, ofs_d;
	logic sout_q, sout_d;
	dlt_word_t dac_q, dac_d;

	assign load_pt = CW'(SAMPLE_SCLKS - 1) - CW'(dac_advance_i);
	assign frame_start = sclk_rise && (cnt_q == CW'(SAMPLE_SCLKS - 1));
	assign load_now = sclk_rise && (cnt_q == load_pt); // R02 R06

	// Rx words arriving after load_now wait for the next sample
	logic [15:0] hold_q, hold_d;

	always_comb begin
		cnt_d = cnt_q;
		tx_d = tx_q;
		txbit_d = txbit_q;
		txsr_d = txsr_q;
		ofs_d = ofs_q;
		sout_d = sout_q;
		dac_d = '{valid: 1'b0, data: dac_q.data};
		if (sclk_rise) begin
			cnt_d = frame_start ? '0 : cnt_q + CW'(1);
		end
		if (load_now) begin
			dac_d = '{valid: 1'b1, data: hold_q}; // R01 R06
		end
		case (tx_q)
			DLT_TX_IDLE: begin
				if (frame_start) begin
					txsr_d = adc_word_i;
					ofs_d = 1'b1; // R03
					tx_d = DLT_TX_SYNC;
				end
			end
			DLT_TX_SYNC: begin
				if (sclk_rise) begin
					ofs_d = 1'b0;
					sout_d = txsr_q[15]; // R04
					txsr_d = {txsr_q[14:0], 1'b0};
					txbit_d = 5'h01;
					tx_d = DLT_TX_SHIFT;
				end
			end
			DLT_TX_SHIFT: begin
				if (sclk_rise) begin
					if (txbit_q == 5'(`DLT_WORD_BITS)) begin
						sout_d = 1'b0;
						txbit_d = `DLT_BITCNT_RESET;
						tx_d = DLT_TX_IDLE;
					end else begin
						sout_d = txsr_q[15]; // R04
						txsr_d = {txsr_q[14:0], 1'b0};
						txbit_d = txbit_q + 5'h01;
					end
				end
			end
			default: begin
				tx_d = DLT_TX_IDLE;
				ofs_d = 1'b0;
				sout_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			cnt_q <= '0;
			tx_q <= DLT_TX_IDLE;
			txbit_q <= `DLT_BITCNT_RESET;
			txsr_q <= `DLT_WORD_RESET;
			ofs_q <= 1'b0;
			sout_q <= 1'b0;
			dac_q <= '{valid: 1'b0, data: `DLT_WORD_RESET};
		end else begin
			cnt_q <= cnt_d;
			tx_q <= tx_d;
			txbit_q <= txbit_d;
			txsr_q <= txsr_d;
			ofs_q <= ofs_d;
			sout_q <= sout_d;
			dac_q <= dac_d;
		end
	end

	// Receive side
	dlt_rx_state_t rx_q, rx_d;
	logic [4:0] rxbit_q, rxbit_d;
	logic [15:0] rxsr_q, rxsr_d;
	logic [2:0] fcnt_q, fcnt_d;
	dlt_word_t ctrl_q, ctrl_d;
	logic rx_done;
	logic [15:0] rx_word;

	assign rx_word = {rxsr_q[14:0], sdi_lvl};
	assign rx_done = (rx_q == DLT_RX_SHIFT) && sclk_fall && (rxbit_q == 5'(`DLT_WORD_BITS - 1));

	always_comb begin
		rx_d = rx_q;
		rxbit_d = rxbit_q;
		rxsr_d = rxsr_q;
		fcnt_d = fcnt_q;
		hold_d = hold_q;
		ctrl_d = '{valid: 1'b0, data: ctrl_q.data};
		case (rx_q)
			DLT_RX_IDLE: begin
				if (sclk_fall && ifs_lvl) begin
					rxbit_d = `DLT_BITCNT_RESET;
					rx_d = DLT_RX_SHIFT;
				end
			end
			DLT_RX_SHIFT: begin
				if (sclk_fall) begin
					rxsr_d = rx_word;
					rxbit_d = rxbit_q + 5'h01;
					if (rx_done) begin
						rx_d = DLT_RX_IDLE;
						if (is_dac_word(rx_word, mixed_mode_i)) begin // R07
							if (fcnt_q == device_count_i) begin
								hold_d = rx_word; // R05
								fcnt_d = 3'h0;
							end else begin
								fcnt_d = fcnt_q + 3'h1; // R07
							end
						end else begin
							ctrl_d = '{valid: 1'b1, data: rx_word};
						end
					end
				end
			end
			default: begin
				rx_d = DLT_RX_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			rx_q <= DLT_RX_IDLE;
			rxbit_q <= `DLT_BITCNT_RESET;
			rxsr_q <= `DLT_WORD_RESET;
			fcnt_q <= 3'h0;
			hold_q <= `DLT_WORD_RESET;
			ctrl_q <= '{valid: 1'b0, data: `DLT_WORD_RESET};
		end else begin
			rx_q <= rx_d;
			rxbit_q <= rxbit_d;
			rxsr_q <= rxsr_d;
			fcnt_q <= fcnt_d;
			hold_q <= hold_d;
			ctrl_q <= ctrl_d;
		end
	end

	assign output_frame_sync_o = ofs_q;
	assign serial_data_out_o = sout_q;
	assign dac_o = dac_q;
	assign ctrl_o = ctrl_q;
	assign holding_o = hold_q;

	// Checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	logic [15:0] snap_q;
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			snap_q <= `DLT_WORD_RESET;
		end else if (frame_start && tx_q == DLT_TX_IDLE) begin
			snap_q <= adc_word_i;
		end
	end

	property p_default_load;
		frame_start && dac_advance_i == '0 |=> dac_o.valid && dac_o.data == $past(hold_q);
	endproperty
	a_default_load: assert property (p_default_load) else $error("no DAC load at frame start"); // R01

	property p_advance_early;
		frame_start && dac_advance_i != '0 |=> !dac_o.valid;
	endproperty
	a_advance_early: assert property (p_advance_early) else $error("advanced load at frame start"); // R02

	property p_frame_sync;
		frame_start && tx_q == DLT_TX_IDLE |=> output_frame_sync_o;
	endproperty
	a_frame_sync: assert property (p_frame_sync) else $error("frame sync did not rise"); // R03

	property p_msb_first;
		output_frame_sync_o && sclk_rise |=> !output_frame_sync_o && serial_data_out_o == snap_q[15];
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("first bit is not the ADC MSB"); // R04

	property p_sixteen_bits;
		tx_q == DLT_TX_SHIFT && sclk_rise && txbit_q == 5'h10 |=> tx_q == DLT_TX_IDLE && !serial_data_out_o;
	endproperty
	a_sixteen_bits: assert property (p_sixteen_bits) else $error("unload not ended after 16 bits"); // R04

	property p_holding;
		rx_done && is_dac_word(rx_word, mixed_mode_i) && fcnt_q == device_count_i
			|=> holding_o == $past(rx_word);
	endproperty
	a_holding: assert property (p_holding) else $error("holding register not updated"); // R05

	property p_advance_point;
		sclk_rise && cnt_q == load_pt |=> dac_o.valid ##1 !dac_o.valid;
	endproperty
	a_advance_point: assert property (p_advance_point) else $error("DAC load not at advance point"); // R06

	property p_mixed_ctrl;
		rx_done && mixed_mode_i && rx_word[15] |=> $stable(holding_o) && $stable(fcnt_q) && ctrl_o.valid;
	endproperty
	a_mixed_ctrl: assert property (p_mixed_ctrl) else $error("control word treated as DAC data"); // R07

	c_frame: cover property (output_frame_sync_o ##1 !output_frame_sync_o);
	c_adv_load: cover property (dac_o.valid && dac_advance_i != '0);
	c_dac_word: cover property (rx_done && !rx_word[15]);
	c_ctrl_word: cover property (ctrl_o.valid);

endmodule

// [core/dlt_params.svh]
// Purpose: Numeric constants for the DAC load timing and serial unload block
// Assumes: Included by bare name wherever the constants are needed
// Notes: Counts are in link bit-clock periods unless stated otherwise
`ifndef DLT_PARAMS_SVH
`define DLT_PARAMS_SVH

`define DLT_WORD_BITS 16
`define DLT_SAMPLE_SCLKS 256
`define DLT_ADV_BITS 4
`define DLT_SYNC_STAGES 3
`define DLT_WORD_RESET 16'h0000
`define DLT_BITCNT_RESET 5'h00

`endif

// [core/dlt_pkg.sv]
// Purpose: Types shared by the DAC load timing block
// Assumes: Word width is fixed at 16 bits
// Notes: States are one-hot with codes written out
package dlt_pkg;

	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} dlt_word_t;

	typedef enum logic [2:0] {
		DLT_TX_IDLE = 3'h1,
		DLT_TX_SYNC = 3'h2,
		DLT_TX_SHIFT = 3'h4
	} dlt_tx_state_t;

	typedef enum logic [1:0] {
		DLT_RX_IDLE = 2'h1,
		DLT_RX_SHIFT = 2'h2
	} dlt_rx_state_t;

endpackage

// [core/dlt_sync_edge.sv]
// Purpose: Three-stage synchroniser with agreement filter and edge flags
// Assumes: Inputs come from outside the sys_clk_i domain
// Notes: First stage feeds only the second; a change counts once stages two and three agree
`timescale 1ns/100ps
`include "dlt_params.svh"

module dlt_sync_edge #(
	parameter int WIDTH = 3
) (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] level_o,
	output logic [WIDTH-1:0] rise_o,
	output logic [WIDTH-1:0] fall_o
);

	if (WIDTH < 1) begin : g_chk
		$error("dlt_sync_edge: WIDTH must be at least 1");
	end

	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		logic s1_q;
		logic s2_q;
		logic s3_q;
		logic lvl_q;
		logic lvl_d;
		logic rise_q;
		logic rise_d;
		logic fall_q;
		logic fall_d;

		always_comb begin
			lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
			rise_d = lvl_d & ~lvl_q;
			fall_d = ~lvl_d & lvl_q;
		end

		always_ff @(posedge sys_clk_i or posedge reset_i) begin
			if (reset_i) begin
				s1_q <= 1'b0;
				s2_q <= 1'b0;
				s3_q <= 1'b0;
				lvl_q <= 1'b0;
				rise_q <= 1'b0;
				fall_q <= 1'b0;
			end else begin
				s1_q <= async_i[i];
				s2_q <= s1_q;
				s3_q <= s2_q;
				lvl_q <= lvl_d;
				rise_q <= rise_d;
				fall_q <= fall_d;
			end
		end

		assign level_o[i] = lvl_q;
		assign rise_o[i] = rise_q;
		assign fall_o[i] = fall_q;
	end

endmodule

// [dv/dlt_dsp_model.sv]
// Purpose: DSP serial port model for the link
// Assumes: Link clock runs free; device shifts on rises and takes input on falls
// Notes: A released data line shows the inverse of its last bit
`timescale 1ns/100ps

module dlt_dsp_model (
	input wire logic output_frame_sync_i,
	input wire logic serial_data_out_i,
	output logic sclk_o,
	output logic input_frame_sync_o,
	output logic serial_data_in_o,
	output logic [15:0] adc_rx_o,
	output logic adc_done_o
);
	int rx_cnt;
	logic [15:0] rx_sr;

	initial begin
		sclk_o = 1'b0;
		input_frame_sync_o = 1'b0;
		serial_data_in_o = 1'b0;
		rx_cnt = 0;
		adc_done_o = 1'b0;
		#137;
		forever #200 sclk_o = ~sclk_o;
	end

	// Device output lags a rise by several sys cycles, so take it on the next rise
	always @(posedge sclk_o) begin
		if (rx_cnt == 0 && output_frame_sync_i === 1'b1) begin
			rx_cnt <= 16;
			adc_done_o <= 1'b0;
		end else if (rx_cnt > 0) begin
			rx_sr <= {rx_sr[14:0], serial_data_out_i};
			rx_cnt <= rx_cnt - 1;
			if (rx_cnt == 1) begin
				adc_rx_o <= {rx_sr[14:0], serial_data_out_i};
				adc_done_o <= 1'b1;
			end
		end
	end

	task automatic send_word(input logic [15:0] word);
		@(posedge sclk_o);
		input_frame_sync_o <= 1'b1;
		@(posedge sclk_o);
		input_frame_sync_o <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			serial_data_in_o <= word[i];
			@(posedge sclk_o);
		end
		serial_data_in_o <= ~word[0];
	endtask
endmodule

// [dv/dlt_core_tb.sv]
// Purpose: Self-checking bench for the DAC load timing block
// Assumes: Sample length shortened to 32 bit clocks
// Notes: Words are sent right after a frame so they land before the load
`timescale 1ns/100ps

module dlt_core_tb;
	import dlt_pkg::*;
	logic sys_clk, reset, sclk, ifs, sdi, ofs, sout, mixed, adc_done, sc_prev;
	logic [15:0] adc_word, holding, adc_rx;
	logic [3:0] adv;
	logic [2:0] dev_cnt;
	dlt_word_t dac, ctrl, ctrl_seen;
	int err_total, check_count;

	dlt_core #(.SAMPLE_SCLKS(32), .ADV_BITS(4)) dut (.sys_clk_i(sys_clk), .reset_i(reset),
		.sclk_i(sclk), .input_frame_sync_i(ifs), .serial_data_in_i(sdi),
		.adc_word_i(adc_word), .dac_advance_i(adv), .mixed_mode_i(mixed),
		.device_count_i(dev_cnt), .output_frame_sync_o(ofs), .serial_data_out_o(sout),
		.dac_o(dac), .ctrl_o(ctrl), .holding_o(holding));
	dlt_dsp_model dsp (.output_frame_sync_i(ofs), .serial_data_out_i(sout), .sclk_o(sclk),
		.input_frame_sync_o(ifs), .serial_data_in_o(sdi), .adc_rx_o(adc_rx),
		.adc_done_o(adc_done));

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// Control pulses last one cycle, so hold on to them
	always @(posedge sys_clk) begin
		if (ctrl.valid === 1'b1) begin
			ctrl_seen <= ctrl;
		end
	end

	task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic complete_run();
		if (err_total == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic wait_ofs();
		int n;
		n = 0;
		while (ofs !== 1'b1 && n < 4000) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		if (n >= 4000) begin
			chk("frame sync wait", 17'h1, 17'h0);
		end
	endtask

	task automatic t_unload(input logic [15:0] w);
		adc_word <= w;
		wait_ofs();
		wait_ofs();
		chk("load at frame", 17'h1, {16'h0, dac.valid});
		repeat (19) @(posedge sclk);
		chk("adc word", {1'b1, w}, {adc_done, adc_rx});
		chk("idle data", 17'h0, {16'h0, sout});
	endtask

	task automatic t_word(input logic [15:0] w, input logic hold_exp);
		logic [15:0] old;
		old = holding;
		ctrl_seen = '0;
		wait_ofs();
		dsp.send_word(w);
		repeat (3) @(posedge sclk);
		chk("holding", {1'b0, hold_exp ? w : old}, {1'b0, holding});
	endtask

	task automatic t_advance(input logic [3:0] a);
		int n;
		int k;
		n = 0;
		k = 0;
		adv <= a;
		wait_ofs();
		// Entered in a frame's first cycle: let that frame sync and its load pass first
		while (ofs === 1'b1 && k < 4000) begin
			@(posedge sys_clk);
			#1;
			k++;
		end
		while (dac.valid !== 1'b1 && k < 4000) begin
			@(posedge sys_clk);
			#1;
			k++;
		end
		sc_prev = sclk;
		while (ofs !== 1'b1 && k < 8000) begin
			@(posedge sys_clk);
			#1;
			if (sclk === 1'b1 && sc_prev === 1'b0) n++;
			sc_prev = sclk;
			k++;
		end
		chk("advance rises", {13'h0, a}, n[16:0]);
	endtask

	initial begin
		reset = 1'b1;
		adc_word = 16'h0000;
		adv = 4'h0;
		mixed = 1'b0;
		dev_cnt = 3'h0;
		err_total = 0;
		check_count = 0;
		ctrl_seen = '0;
		repeat (8) @(posedge sys_clk);
		reset <= 1'b0;
		t_unload(16'hA5C3);
		t_unload(16'h5A3C);
		t_word(16'h9F0E, 1'b1);
		wait_ofs();
		chk("dac load data", {1'b1, 16'h9F0E}, dac);
		t_advance(4'h5);
		t_advance(4'hF);
		t_advance(4'h0);
		mixed <= 1'b1;
		dev_cnt <= 3'h1;
		t_word(16'h1111, 1'b0);
		t_word(16'h8ABC, 1'b0);
		chk("control word", {1'b1, 16'h8ABC}, ctrl_seen);
		t_word(16'h2222, 1'b1);
		complete_run();
	end

	initial begin
		#1000000;
		err_total++;
		complete_run();
	end
endmodule
